// [hdl/plt_pkg.sv]
/*
  plt_pkg: constants, register map and carrier types for the programmable logic tile.
  Assumes a single 10 MHz clock domain and a plain address/strobe register port.
*/
package plt_pkg;

  // geometry
  localparam int PLT_SLICES     = 8;
  localparam int PLT_LUT_INPUTS = 4;
  localparam int PLT_LUT_DEPTH  = 16;
  localparam int PLT_GBUFS      = 8;
  localparam int PLT_ADDR_W     = 5;
  localparam int PLT_DATA_W     = 16;

  // clock
  localparam int PLT_CLK_HZ     = 10000000;

  // register offsets
  localparam logic [4:0] PLT_LUT_BASE = 5'h00;
  localparam logic [4:0] PLT_OUT_SEL  = 5'h08;
  localparam logic [4:0] PLT_SR_CTRL  = 5'h09;
  localparam logic [4:0] PLT_CLK_SEL  = 5'h0A;
  localparam logic [4:0] PLT_CONFIG   = 5'h0B;
  localparam logic [4:0] PLT_STATUS   = 5'h0C;

  // field positions
  localparam int PLT_SR_USED_BIT   = 0;
  localparam int PLT_SR_SYNC_BIT   = 1;
  localparam int PLT_SET_VAL_LSB   = 8;
  localparam int PLT_CLK_FAB_BIT   = 3;
  localparam int PLT_CFG_ACT_BIT   = 0;
  localparam int PLT_STAT_CARRY    = 8;
  localparam int PLT_STAT_CFG      = 9;

  // reset values
  localparam logic [15:0] PLT_LUT_RST     = 16'h0000;
  localparam logic [7:0]  PLT_OUT_SEL_RST = 8'h00;
  localparam logic [1:0]  PLT_SR_CTL_RST  = 2'h0;
  localparam logic [7:0]  PLT_SET_VAL_RST = 8'h00;
  localparam logic [3:0]  PLT_CLK_SEL_RST = 4'h8;
  localparam logic        PLT_CFG_ACT_RST = 1'b1;
  localparam logic        PLT_FLOP_WAKE   = 1'b0;

  // timing counts
  localparam logic [1:0]  PLT_WAKE_HOLD_CYC = 2'h2;

  // per-slice configuration
  typedef struct packed {
    logic [15:0] table_bits;
    logic        out_reg;
    logic        set_value;
  } plt_slice_cfg_t;

  // tile-wide control shared by every slice
  typedef struct packed {
    logic tick;
    logic ce;
    logic sr_async;
    logic sr_sync;
    logic global_rst;
  } plt_ctrl_t;

endpackage : plt_pkg

// [hdl/plt_logic_slice.sv]
/*
  plt_logic_slice: one logic slice - four-input table, storage flop, carry logic, output select.
  Assumes tile-wide control arrives already resolved and in the clk_in domain.
*/
`timescale 1ns/1ps
module plt_logic_slice
  import plt_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  // configuration and shared control
  input  wire plt_slice_cfg_t            cfg_in,
  input  wire plt_ctrl_t                 ctrl_in,
  // data
  input  wire logic [PLT_LUT_INPUTS-1:0] table_in,
  input  wire logic                      carry_in,
  output logic                           data_out,
  output logic                           carry_out,
  output logic                           stored_out
);

  logic table_result;
  logic slice_storage_flop;

  // sixteen-entry one-bit read-only table addressed by the four inputs
  assign table_result = cfg_in.table_bits[table_in];

  // carry from inputs 1 and 2 with the chained carry
  assign carry_out = (table_in[1] & table_in[2]) | ((table_in[1] | table_in[2]) & carry_in);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      slice_storage_flop <= PLT_FLOP_WAKE;
    end else if (ctrl_in.global_rst) begin
      slice_storage_flop <= PLT_FLOP_WAKE;
    end else if (ctrl_in.sr_async) begin
      slice_storage_flop <= cfg_in.set_value;
    end else if (ctrl_in.tick && ctrl_in.sr_sync) begin
      slice_storage_flop <= cfg_in.set_value;
    end else if (ctrl_in.tick && ctrl_in.ce) begin
      slice_storage_flop <= table_result;
    end
  end

  assign data_out   = cfg_in.out_reg ? slice_storage_flop : table_result;
  assign stored_out = slice_storage_flop;

endmodule : plt_logic_slice

// [hdl/plt_logic_tile.sv]
/*
  plt_logic_tile: a logic tile of eight slices with shared clock select, clock enable,
  set/reset, global wake-up reset, carry chain and a configuration register port.
  Assumes fabric and neighbour signals are in the clk_in domain; global buffer pins are not.
*/
// Our own choices: strobed register access and the placing of the registers.
// Summary of operation
// - the tile holds exactly eight slices joined inside the tile
// - each slice has one four-input table and one storage flop
// - the table gives any function of up to four inputs, combinationally
// - the table acts as a sixteen-by-one read-only memory addressed by inputs
// - each flop is D-type with optional clock enable and set/reset
// - every flop is cleared by global reset right after configuration
// - each slice has carry logic; carry enters and leaves the tile
// - one tile clock enable gates all eight flops together
// - one tile set/reset, chosen asynchronous or synchronous, serves every slice
// - tile clock comes from one of eight global buffers or fabric
// - each slice output selects table result or stored flop value
// - with set/reset unused a flop is only cleared after configuration
// - global reset holds through configuration, forcing flops to reset value
`timescale 1ns/1ps
module plt_logic_tile
  import plt_pkg::*;
#(
  parameter int NUM_SLICES = PLT_SLICES
)(
  // clock and reset
  input  wire logic                             clk_in,
  input  wire logic                             sys_rst_in,
  // register port
  input  wire logic [PLT_ADDR_W-1:0]            reg_addr_in,
  input  wire logic [PLT_DATA_W-1:0]            reg_wdata_in,
  input  wire logic                             reg_wr_in,
  input  wire logic                             reg_rd_in,
  output logic      [PLT_DATA_W-1:0]            reg_rdata_out,
  // fabric side controls and clocks
  input  wire logic [PLT_GBUFS-1:0]             global_clock_buffer_in,
  input  wire logic                             fabric_clk_in,
  input  wire logic                             tile_ce_in,
  input  wire logic                             tile_sr_in,
  // slice data and carry chain
  input  wire logic [NUM_SLICES*PLT_LUT_INPUTS-1:0] table_in,
  input  wire logic                             carry_chain_in_in,
  output logic      [NUM_SLICES-1:0]            slice_data_out,
  output logic                                  carry_chain_out_out
);

  // register map and status word are laid out for eight slices
  if (NUM_SLICES != PLT_SLICES) begin : gen_bad_slices
    $error("plt_logic_tile: NUM_SLICES must be eight");
  end

  // configuration state
  logic [PLT_LUT_DEPTH-1:0] table_bits [NUM_SLICES];
  logic [NUM_SLICES-1:0]    out_sel;
  logic [NUM_SLICES-1:0]    set_value;
  logic                     sr_used;
  logic                     sr_sync_mode;
  logic [3:0]               clk_sel;
  logic                     cfg_active;
  logic [1:0]               wake_cnt;
  logic                     global_rst;

  // clock source tracking
  logic [PLT_GBUFS-1:0]     global_clock_buffer_meta;
  logic [PLT_GBUFS-1:0]     global_clock_buffer_sync;
  logic                     clk_src;
  logic                     clk_src_d;

  // slice interconnect
  plt_ctrl_t                ctrl;
  plt_slice_cfg_t           slice_cfg [NUM_SLICES];
  logic [NUM_SLICES:0]      carry;
  logic [NUM_SLICES-1:0]    slice_data;
  logic [NUM_SLICES-1:0]    slice_stored;

  // ---------------- register writes ----------------

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_SLICES; i++) begin
        table_bits[i] <= PLT_LUT_RST;
      end
    end else if (reg_wr_in && reg_addr_in < PLT_OUT_SEL) begin
      table_bits[reg_addr_in[2:0]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_sel <= PLT_OUT_SEL_RST;
    end else if (reg_wr_in && reg_addr_in == PLT_OUT_SEL) begin
      out_sel <= reg_wdata_in[NUM_SLICES-1:0];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sr_used      <= PLT_SR_CTL_RST[PLT_SR_USED_BIT];
      sr_sync_mode <= PLT_SR_CTL_RST[PLT_SR_SYNC_BIT];
      set_value    <= PLT_SET_VAL_RST;
    end else if (reg_wr_in && reg_addr_in == PLT_SR_CTRL) begin
      sr_used      <= reg_wdata_in[PLT_SR_USED_BIT];
      sr_sync_mode <= reg_wdata_in[PLT_SR_SYNC_BIT];
      set_value    <= reg_wdata_in[PLT_SET_VAL_LSB +: NUM_SLICES];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clk_sel <= PLT_CLK_SEL_RST;
    end else if (reg_wr_in && reg_addr_in == PLT_CLK_SEL) begin
      clk_sel <= reg_wdata_in[3:0];
    end
  end

  // configuration phase and the wake-up clear that follows it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_active <= PLT_CFG_ACT_RST;
    end else if (reg_wr_in && reg_addr_in == PLT_CONFIG) begin
      cfg_active <= reg_wdata_in[PLT_CFG_ACT_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_cnt <= 2'h0;
    end else if (cfg_active) begin
      wake_cnt <= PLT_WAKE_HOLD_CYC;
    end else if (wake_cnt != 2'h0) begin
      wake_cnt <= wake_cnt - 2'h1;
    end
  end

  // held for all of configuration and a short tail after it
  assign global_rst = cfg_active | (wake_cnt != 2'h0);

  // ---------------- clock selection ----------------

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      global_clock_buffer_meta <= '0;
      global_clock_buffer_sync <= '0;
    end else begin
      global_clock_buffer_meta <= global_clock_buffer_in;
      global_clock_buffer_sync <= global_clock_buffer_meta;
    end
  end

  // fabric when the top select bit is set, else buffer 0..7
  assign clk_src = clk_sel[PLT_CLK_FAB_BIT] ? fabric_clk_in : global_clock_buffer_sync[clk_sel[2:0]];

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clk_src_d <= 1'b0;
    end else begin
      clk_src_d <= clk_src;
    end
  end

  // ---------------- shared control ----------------

  always_comb begin
    ctrl.tick       = clk_src & ~clk_src_d;
    ctrl.ce         = tile_ce_in;
    ctrl.sr_async   = sr_used & ~sr_sync_mode & tile_sr_in;
    ctrl.sr_sync    = sr_used & sr_sync_mode & tile_sr_in;
    ctrl.global_rst = global_rst;
  end

  // ---------------- slices and carry chain ----------------

  assign carry[0] = carry_chain_in_in;

  for (genvar g = 0; g < NUM_SLICES; g++) begin : gen_slice
    assign slice_cfg[g] = '{table_bits: table_bits[g], out_reg: out_sel[g], set_value: set_value[g]};

    plt_logic_slice u_logic_slice (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .cfg_in     (slice_cfg[g]),
      .ctrl_in    (ctrl),
      .table_in   (table_in[g*PLT_LUT_INPUTS +: PLT_LUT_INPUTS]),
      .carry_in   (carry[g]),
      .data_out   (slice_data[g]),
      .carry_out  (carry[g+1]),
      .stored_out (slice_stored[g])
    );
  end

  // ---------------- registered outputs ----------------

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      slice_data_out      <= '0;
      carry_chain_out_out <= 1'b0;
    end else begin
      slice_data_out      <= slice_data;
      carry_chain_out_out <= carry[NUM_SLICES];
    end
  end

  // ---------------- register reads ----------------

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= '0;
    end else if (reg_addr_in < PLT_OUT_SEL) begin
      reg_rdata_out <= table_bits[reg_addr_in[2:0]];
    end else if (reg_addr_in == PLT_OUT_SEL) begin
      reg_rdata_out <= {8'h00, out_sel};
    end else if (reg_addr_in == PLT_SR_CTRL) begin
      reg_rdata_out <= {set_value, 6'h00, sr_sync_mode, sr_used};
    end else if (reg_addr_in == PLT_CLK_SEL) begin
      reg_rdata_out <= {12'h000, clk_sel};
    end else if (reg_addr_in == PLT_CONFIG) begin
      reg_rdata_out <= {15'h0000, cfg_active};
    end else if (reg_addr_in == PLT_STATUS) begin
      reg_rdata_out <= {6'h00, cfg_active, carry[NUM_SLICES], slice_stored};
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule : plt_logic_tile

// [tb/plt_logic_tile_assertions.sv]
/*
  plt_logic_tile_checker: port-level checks of the logic tile, with a shadow of its configuration.
  Assumes one clk_in domain and register writes seen on the strobe port.
*/
`timescale 1ns/1ps
module plt_logic_tile_checker
  import plt_pkg::*;
#(
  parameter int NUM_SLICES = PLT_SLICES
)(
  input wire logic                  clk_in,
  input wire logic                  sys_rst_in,
  input wire logic [4:0]            reg_addr_in,
  input wire logic [15:0]           reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [15:0]           reg_rdata_out,
  input wire logic                  tile_ce_in,
  input wire logic                  tile_sr_in,
  input wire logic [31:0]           table_in,
  input wire logic                  carry_chain_in_in,
  input wire logic [NUM_SLICES-1:0] slice_data_out,
  input wire logic                  carry_chain_out_out
);
  logic [15:0] lut [8];
  logic [7:0]  osel, sv, lexp;
  logic        used, sync, cfg;
  logic [2:0]  calm;
  logic [8:0]  cexp;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lut  <= '{default: 16'h0000};
      osel <= 8'h00;
      sv   <= 8'h00;
      used <= 1'b0;
      sync <= 1'b0;
      cfg  <= 1'b1;
    end else if (reg_wr_in) begin
      if (reg_addr_in < PLT_OUT_SEL) lut[reg_addr_in[2:0]] <= reg_wdata_in;
      if (reg_addr_in == PLT_OUT_SEL) osel <= reg_wdata_in[7:0];
      if (reg_addr_in == PLT_SR_CTRL) begin
        used <= reg_wdata_in[0];
        sync <= reg_wdata_in[1];
        sv   <= reg_wdata_in[15:8];
      end
      if (reg_addr_in == PLT_CONFIG) cfg <= reg_wdata_in[0];
    end
  end
  // cycles since configuration ended (cfg low), saturating
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) calm <= 3'h0;
    else if (cfg) calm <= 3'h0;
    else if (calm != 3'h7) calm <= calm + 3'h1;
  end
  always_comb begin
    cexp[0] = carry_chain_in_in;
    for (int i = 0; i < 8; i++) begin
      lexp[i]   = lut[i][table_in[4*i +: 4]];
      cexp[i+1] = (table_in[4*i+1] & table_in[4*i+2]) | ((table_in[4*i+1] | table_in[4*i+2]) & cexp[i]);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_lut_wr; reg_wr_in && reg_addr_in < PLT_OUT_SEL; endsequence
  sequence s_rd_back; reg_rd_in && reg_addr_in == $past(reg_addr_in, 2); endsequence
  sequence s_sr_on; tile_sr_in && used && !sync && calm == 3'h7 && !reg_wr_in; endsequence
  sequence s_quiet; !tile_ce_in && (!tile_sr_in || !used) && !reg_wr_in && calm == 3'h7; endsequence
  property p_lut_rw; s_lut_wr ##2 s_rd_back |=> reg_rdata_out == $past(reg_wdata_in, 3); endproperty
  property p_carry; !$past(sys_rst_in) |-> carry_chain_out_out == $past(cexp[8]); endproperty
  property p_comb; !$past(sys_rst_in) |-> ((slice_data_out ^ $past(lexp)) & ~$past(osel) & ~$past(osel, 2)) == 8'h00;
  endproperty
  property p_async_sr; s_sr_on [*3] |-> ((slice_data_out ^ sv) & osel) == 8'h00; endproperty
  property p_hold; s_quiet [*3] |-> $stable(slice_data_out & osel); endproperty
  property p_wake; cfg [*3] |-> (slice_data_out & osel & $past(osel)) == 8'h00; endproperty
  property p_status_cfg;
    reg_rd_in && reg_addr_in == PLT_STATUS && cfg |=> reg_rdata_out[9] && reg_rdata_out[7:0] == 8'h00;
  endproperty
  property p_status_carry; reg_rd_in && reg_addr_in == PLT_STATUS |=> reg_rdata_out[8] == $past(cexp[8]); endproperty
  a_lut_rw: assert property (p_lut_rw) else $error("table readback wrong");
  a_carry: assert property (p_carry) else $error("carry out wrong");
  a_comb: assert property (p_comb) else $error("table output wrong");
  a_async_sr: assert property (p_async_sr) else $error("async set/reset wrong");
  a_hold: assert property (p_hold) else $error("flop changed without enable");
  a_wake: assert property (p_wake) else $error("flop not cleared in wake reset");
  a_status_cfg: assert property (p_status_cfg) else $error("status during configuration wrong");
  a_status_carry: assert property (p_status_carry) else $error("status carry wrong");
endmodule : plt_logic_tile_checker

bind plt_logic_tile plt_logic_tile_checker #(.NUM_SLICES(NUM_SLICES)) u_chk (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .tile_ce_in(tile_ce_in), .tile_sr_in(tile_sr_in),
  .table_in(table_in), .carry_chain_in_in(carry_chain_in_in), .slice_data_out(slice_data_out),
  .carry_chain_out_out(carry_chain_out_out));

// [tb/plt_fabric_model.sv]
/*
  plt_fabric_model: fabric and global buffer clock sources facing the tile.
  Assumes the tile samples them in the clk_in domain.
*/
`timescale 1ns/1ps
module plt_fabric_model (
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  // pacing
  input  wire logic  slow_in,
  input  wire logic  hold_in,
  // clock sources
  output logic       fabric_clk_out,
  output logic [7:0] global_clock_buffer_out
);
  logic [4:0] cnt;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) cnt <= 5'h00;
    else cnt <= cnt + 5'h01;
  end
  // slow pacing stretches the fabric clock eightfold
  // hold parks the fabric clock low, so no tick reaches the tile while it selects the fabric
  assign fabric_clk_out = hold_in ? 1'b0 : (slow_in ? cnt[4] : cnt[1]);
  assign global_clock_buffer_out       = {cnt[4:1], cnt[3:0]};
endmodule : plt_fabric_model

// [tb/plt_logic_tile_tb.sv]
/*
  plt_logic_tile_tb: self-checking bench of the logic tile through registers and status.
  Assumes the fabric model supplies the tile clock sources.
*/
`timescale 1ns/1ps
module plt_logic_tile_tb
  import plt_pkg::*;
;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_d = 1'b0;
  logic        tile_ce_in = 1'b0, tile_sr_in = 1'b0, cin = 1'b0, slow = 1'b0, hold = 1'b0, fab, cout;
  logic [4:0]  reg_addr_in = 5'h00;
  logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, lut [8], exq [$], ev;
  logic [31:0] table_in = 32'h0000_0000;
  logic [7:0]  slice_data_out, global_clock_buffer, st;
  int          fails = 0, checked = 0, seed = 70;
  plt_logic_tile dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .global_clock_buffer_in(global_clock_buffer), .fabric_clk_in(fab), .tile_ce_in(tile_ce_in), .tile_sr_in(tile_sr_in),
    .table_in(table_in), .carry_chain_in_in(cin), .slice_data_out(slice_data_out), .carry_chain_out_out(cout));
  plt_fabric_model u_fab (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .slow_in(slow), .hold_in(hold),
    .fabric_clk_out(fab), .global_clock_buffer_out(global_clock_buffer));
  initial forever #50 clk_in = ~clk_in;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    exq.push_back(e);
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
  endtask : rd
  // direct look at the slice outputs and tile carry out, settled for several cycles
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] carry_and_slice_out exp %h got %h", exp, seen);
    end
  endtask : chk
  // expected status word from stored bits and the present carry chain
  function automatic logic [15:0] status(input logic [7:0] s, input logic cf);
    logic c;
    c = cin;
    for (int i = 0; i < 8; i++) c = (table_in[4*i+1] & table_in[4*i+2]) | ((table_in[4*i+1] | table_in[4*i+2]) & c);
    return {6'h00, cf, c, s};
  endfunction : status
  function automatic logic [7:0] look();
    for (int i = 0; i < 8; i++) look[i] = lut[i][table_in[4*i +: 4]];
  endfunction : look
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk_in) begin
    if (rd_d) begin
      checked++;
      if (reg_rdata_out !== exq[0]) begin
        fails++;
        $display("[ERR] reg_rdata_out exp %h got %h", exq[0], reg_rdata_out);
      end
      void'(exq.pop_front());
    end
    rd_d <= reg_rd_in;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(PLT_CLK_SEL, 16'h0008);
    rd(PLT_CONFIG, 16'h0001);
    rd(PLT_OUT_SEL, 16'h0000);
    rd(PLT_SR_CTRL, 16'h0000);
    rd(5'h03, 16'h0000);
    rd(PLT_STATUS, status(8'h00, 1'b1));
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      lut[i] = 16'($random(seed));
      wr(5'(i), lut[i]);
      rd(5'(i), lut[i]);
    end
    wr(PLT_CONFIG, 16'h0000);
    wr(PLT_OUT_SEL, 16'h00FF);
    tile_ce_in <= 1'b1;
    // every buffer, then the fabric at two paces
    for (int k = 0; k < 10; k++) begin
      wr(PLT_CLK_SEL, 16'(k > 8 ? 8 : k));
      slow <= k[0];
      table_in <= $random(seed);
      cin <= 1'($random(seed));
      repeat (80) @(posedge clk_in);
      ev = status(look(), 1'b0);
      chk({cout, slice_data_out}, ev[8:0]);
      rd(PLT_STATUS, ev);
    end
    // fabric parked: no tick, so nothing loads until it runs again
    st = look();
    hold <= 1'b1;
    table_in <= $random(seed);
    repeat (80) @(posedge clk_in);
    rd(PLT_STATUS, status(st, 1'b0));
    hold <= 1'b0;
    repeat (80) @(posedge clk_in);
    rd(PLT_STATUS, status(look(), 1'b0));
    tile_ce_in <= 1'b0;
    st = look();
    table_in <= $random(seed);
    repeat (80) @(posedge clk_in);
    rd(PLT_STATUS, status(st, 1'b0));
    tile_sr_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    rd(PLT_STATUS, status(st, 1'b0));
    wr(PLT_SR_CTRL, 16'hA501);
    repeat (4) @(posedge clk_in);
    rd(PLT_STATUS, status(8'hA5, 1'b0));
    tile_sr_in <= 1'b0;
    wr(PLT_SR_CTRL, 16'h3C03);
    tile_sr_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    rd(PLT_STATUS, status(8'h3C, 1'b0));
    wr(PLT_CONFIG, 16'h0001);
    rd(PLT_STATUS, status(8'h00, 1'b1));
    // combinational outputs with fresh inputs
    wr(PLT_OUT_SEL, 16'h0000);
    table_in <= $random(seed);
    cin <= 1'($random(seed));
    repeat (4) @(posedge clk_in);
    ev = status(look(), 1'b0);
    chk({cout, slice_data_out}, ev[8:0]);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(PLT_OUT_SEL, 16'h0000);
    repeat (2) @(posedge clk_in);
    end_of_test();
  end
endmodule : plt_logic_tile_tb
